// [pas_defs.svh]
/*
 * Shared constants for the strap-address loader: register offsets, field positions, reset values, timing.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef PAS_DEFS_SVH
`define PAS_DEFS_SVH

// register space
`define PAS_REG_ADDR_W 5
`define PAS_DATA_W 16
`define PAS_PHY_ADDR_W 5
`define PAS_REG_BASIC_CONTROL 5'h00
`define PAS_REG_PHY_CONTROL 5'h19

// field positions
`define PAS_BASIC_CONTROL_REGISTER_ISOLATE_BIT 10
`define PAS_CTRL_STRAP_LSB 0
`define PAS_CTRL_STRAP_MSB 4
`define PAS_CTRL_RW_LSB 5
`define PAS_CTRL_RW_MSB 15

// reset values
`define PAS_BASIC_CONTROL_REGISTER_RESET 16'h0000
`define PAS_CTRL_RW_RESET 11'h000
`define PAS_ISOLATE_ADDR 5'h00
`define PAS_READ_UNMAPPED 16'h0000

// management frame
`define PAS_OP_READ 2'h2
`define PAS_OP_WRITE 2'h1
`define PAS_HDR_W 12
`define PAS_HDR_LAST 4'hb
`define PAS_DATA_LAST 4'hf
`define PAS_TA_LAST 4'h1
`define PAS_PREAMBLE_ONES 6'h20
`define PAS_CNT_ONE 4'h1
`define PAS_ONES_ONE 6'h01
`define PAS_ONES_W 6
`define PAS_CNT_W 4
`define PAS_HDR_OP_MSB 11
`define PAS_HDR_OP_LSB 10
`define PAS_HDR_PHY_MSB 9
`define PAS_HDR_PHY_LSB 5
`define PAS_HDR_REG_MSB 4
`define PAS_HDR_REG_LSB 0

// timing: straps must have crossed the synchroniser before they are frozen
`define PAS_CLK_PERIOD_NS 8
`define PAS_STRAP_SETTLE_NS 32
`define PAS_STRAP_SETTLE_CYC ((`PAS_STRAP_SETTLE_NS + `PAS_CLK_PERIOD_NS - 1) / `PAS_CLK_PERIOD_NS)
`define PAS_SETTLE_W 4
`define PAS_PIN_W 8

`endif

// [pas_pin_sync.sv]
/*
 * Four-flop input filter for pins from outside the core clock domain.
 * Assumes one free-running clock; the output changes only once stages two and three agree.
 */
`timescale 1ns/1ns

module pas_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic out_reg;
      wire agree = (s2_reg == s3_reg);
      // s1 feeds only s2, so a metastable first stage never reaches logic
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          out_reg <= 1'b0;
        end else begin
          s1_reg <= pin_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (agree) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign pin_out[i] = out_reg;
    end
  endgenerate

endmodule

// [pas_pkg.sv]
/*
 * Types of the strap-address loader: frame states, init states, pin bundle.
 * Assumes pas_defs.svh is on the include path.
 */
`include "pas_defs.svh"

package pas_pkg;

  typedef enum logic [2:0] {
    PAS_MF_IDLE = 3'h0,
    PAS_MF_START = 3'h1,
    PAS_MF_HDR = 3'h2,
    PAS_MF_TA = 3'h3,
    PAS_MF_DATA = 3'h4
  } pas_frame_st_t;

  typedef enum logic [0:0] {
    PAS_INIT_HOLD = 1'h0,
    PAS_INIT_RUN = 1'h1
  } pas_init_st_t;

  typedef struct packed {
    logic hw_reset;
    logic mdc;
    logic mdio;
    logic [`PAS_PHY_ADDR_W-1:0] strap;
  } pas_pins_t;

endpackage

// [pas_sme_model.sv]
/* station manager and strap resistors facing the strap loader
   assumes the bench starts frames only after INIT_DONE */
`timescale 1ns/1ns
`include "pas_defs.svh"
module pas_sme_model (
  // pacing clock
  input wire logic clk,
  // device side
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // board side
  output logic mdc,
  output logic mdio,
  output logic [4:0] strap
);
  logic drv;
  logic dat;
  // pull-up wins when nobody drives
  assign mdio = mdio_oe ? mdio_out : (drv ? dat : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    dat = 1'b1;
    strap = 5'h00;
  end
  // straps are board resistors: only this model drives them
  task automatic set_strap(input logic [4:0] s);
    strap = s;
  endtask
  // half period of 10 core cycles stays well clear of the pin filter
  task automatic half();
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic bitx(input logic d, input logic en, output logic s);
    drv = en;
    dat = d;
    mdc = 1'b0;
    half();
    s = mdio;
    mdc = 1'b1;
    half();
  endtask
  // full preamble every frame; one idle bit with the line released at the end
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic s;
    logic w;
    w = (op == `PAS_OP_WRITE);
    hdr = {32'hffffffff, 2'h1, op, pa, ra};
    for (int i = 45; i >= 0; i--) bitx(hdr[i], 1'b1, s);
    bitx(1'b1, w, s);
    bitx(1'b0, w, s);
    for (int i = 15; i >= 0; i--) begin
      bitx(wd[i], w, s);
      rd[i] = s;
    end
    bitx(1'b1, 1'b0, s);
  endtask
endmodule

// [pas_strap_chk.sv]
/* timing checks on the strap loader ports
   assumes straps stay stable through each reset */
`timescale 1ns/1ns
module pas_strap_chk (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // pins
  input wire logic RESET,
  input wire logic [4:0] STRAP_ADDRESS_PINS,
  input wire logic MDC,
  input wire logic MDIO_IN,
  input wire logic MDIO_OUT,
  input wire logic MDIO_OE,
  // status
  input wire logic [4:0] PHY_ADDRESS,
  input wire logic ISOLATE,
  input wire logic INIT_DONE
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  a_addr_strap: assert property ($rose(INIT_DONE) |-> PHY_ADDRESS == $past(STRAP_ADDRESS_PINS, 5))
    else $error("address not from straps");
  a_iso_zero: assert property ($rose(INIT_DONE) |-> ISOLATE == (PHY_ADDRESS == 5'h00))
    else $error("isolate wrong at init");
  a_addr_held: assert property (INIT_DONE && $past(INIT_DONE) |-> $stable(PHY_ADDRESS))
    else $error("address moved");
  a_reset_hold: assert property (RESET [*8] |-> !INIT_DONE)
    else $error("reset ignored");
  a_reset_quiet: assert property (RESET [*8] |-> !MDIO_OE)
    else $error("drive during reset");
  a_init_bound: assert property ($fell(RESET) |-> ##[1:30] INIT_DONE)
    else $error("init too slow");
  a_ta_zero: assert property ($rose(MDIO_OE) |-> !MDIO_OUT && INIT_DONE)
    else $error("turnaround not zero");
  a_oe_on_mdc: assert property ($rose(MDIO_OE) |-> MDC && $past(MDC, 3))
    else $error("drive not after mdc rise");
  a_out_on_mdc: assert property (MDIO_OE && $changed(MDIO_OUT) |-> MDC)
    else $error("data moved with mdc low");
  c_isolate: cover property ($rose(INIT_DONE) && ISOLATE);
  c_iso_read: cover property ($rose(MDIO_OE) && ISOLATE);
  c_hw_reset: cover property ($fell(RESET));
endmodule

// [phy_address_strap_reset.sv]
/*
 * Strap-address loader with hardware reset handling and a serial management slave.
 * Assumes straps are static board resistors and management runs well below the core clock.
 */
// How it works
// - five strap pins give the management address, any of 32 values
// - an all-zero strap address puts the device into isolation
// - strap pin n is captured into control register bit n during reset
// - reset pin is active high and starts full reinitialisation
// - hardware reset returns every register bit to its default
// - hardware reset re-samples the straps instead of keeping old values
// - two 16-bit registers (basic control, PHY control) in a 32-address space, reachable over the serial management pins
// - isolate bit set at reset when strap address is zero, else cleared
// - an all-zero address still answers management frames addressed to it
`timescale 1ns/1ns
`include "pas_defs.svh"

module phy_address_strap_reset (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // pins
  input wire logic RESET,
  input wire logic [`PAS_PHY_ADDR_W-1:0] STRAP_ADDRESS_PINS,
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE,
  // status
  output logic [`PAS_PHY_ADDR_W-1:0] PHY_ADDRESS,
  output logic ISOLATE,
  output logic INIT_DONE
);

  pas_pkg::pas_pins_t pins_raw;
  pas_pkg::pas_pins_t pins;

  assign pins_raw = '{hw_reset: RESET, mdc: MDC, mdio: MDIO_IN, strap: STRAP_ADDRESS_PINS};

  pas_pin_sync #(
    .WIDTH(`PAS_PIN_W)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .pin_in(pins_raw),
    .pin_out(pins)
  );

  // init sequencing
  pas_pkg::pas_init_st_t init_reg, init_next;
  logic [`PAS_SETTLE_W-1:0] settle_reg;
  logic [`PAS_SETTLE_W-1:0] settle_next;
  wire hw_reset = pins.hw_reset;
  wire settle_done = (settle_reg == `PAS_SETTLE_W'(`PAS_STRAP_SETTLE_CYC));
  wire holding = (init_reg == pas_pkg::PAS_INIT_HOLD);

  always_comb begin
    init_next = init_reg;
    settle_next = settle_reg;
    if (hw_reset) begin
      init_next = pas_pkg::PAS_INIT_HOLD;
      settle_next = '0;
    end else if (holding) begin
      if (settle_done) begin
        init_next = pas_pkg::PAS_INIT_RUN;
      end else begin
        settle_next = settle_reg + `PAS_CNT_ONE;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      init_reg <= pas_pkg::PAS_INIT_HOLD;
      settle_reg <= '0;
    end else begin
      init_reg <= init_next;
      settle_reg <= settle_next;
    end
  end

  // registers
  logic [`PAS_PHY_ADDR_W-1:0] strap_reg;
  logic [`PAS_DATA_W-1:0] basic_control_register_reg;
  logic [`PAS_CTRL_RW_MSB:`PAS_CTRL_RW_LSB] ctrl_rw_reg;
  logic wr_commit;
  logic [`PAS_REG_ADDR_W-1:0] wr_addr;
  logic [`PAS_DATA_W-1:0] wr_data;

  wire strap_zero = (pins.strap == `PAS_ISOLATE_ADDR);
  wire [`PAS_DATA_W-1:0] basic_control_register_default = `PAS_BASIC_CONTROL_REGISTER_RESET | (`PAS_DATA_W'(strap_zero) << `PAS_BASIC_CONTROL_REGISTER_ISOLATE_BIT);
  wire wr_basic_control_register = wr_commit && (wr_addr == `PAS_REG_BASIC_CONTROL);
  wire wr_ctrl = wr_commit && (wr_addr == `PAS_REG_PHY_CONTROL);

  // straps are re-captured every cycle while held, so the last settled level wins
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap_reg <= '0;
      basic_control_register_reg <= `PAS_BASIC_CONTROL_REGISTER_RESET;
      ctrl_rw_reg <= `PAS_CTRL_RW_RESET;
    end else if (holding) begin
      strap_reg <= pins.strap;
      basic_control_register_reg <= basic_control_register_default;
      ctrl_rw_reg <= `PAS_CTRL_RW_RESET;
    end else begin
      if (wr_basic_control_register) begin
        basic_control_register_reg <= wr_data;
      end
      if (wr_ctrl) begin
        ctrl_rw_reg <= wr_data[`PAS_CTRL_RW_MSB:`PAS_CTRL_RW_LSB];
      end
    end
  end

  // unmapped addresses of the 32-entry space read as zero
  function automatic logic [`PAS_DATA_W-1:0] reg_read(input logic [`PAS_REG_ADDR_W-1:0] addr);
    logic [`PAS_DATA_W-1:0] val;
    val = `PAS_READ_UNMAPPED;
    if (addr == `PAS_REG_BASIC_CONTROL) begin
      val = basic_control_register_reg;
    end else if (addr == `PAS_REG_PHY_CONTROL) begin
      val = {ctrl_rw_reg, strap_reg};
    end
    return val;
  endfunction

  // management frame slave
  pas_pkg::pas_frame_st_t mf_reg, mf_next;
  logic mdc_prev_reg;
  logic pre_seen_reg, pre_seen_next;
  logic [`PAS_ONES_W-1:0] ones_reg, ones_next;
  logic [`PAS_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`PAS_HDR_W-1:0] hdr_reg, hdr_next;
  logic is_read_reg, is_read_next;
  logic [`PAS_REG_ADDR_W-1:0] ra_reg, ra_next;
  logic [`PAS_DATA_W-1:0] sh_reg, sh_next;
  logic out_reg, out_next;
  logic oe_reg, oe_next;

  wire mdc_rise = pins.mdc && !mdc_prev_reg;
  wire bit_in = pins.mdio;
  wire [`PAS_HDR_W-1:0] hdr_full = {hdr_reg[`PAS_HDR_W-2:0], bit_in};
  wire [1:0] hdr_op = hdr_full[`PAS_HDR_OP_MSB:`PAS_HDR_OP_LSB];
  wire [`PAS_PHY_ADDR_W-1:0] hdr_phy = hdr_full[`PAS_HDR_PHY_MSB:`PAS_HDR_PHY_LSB];
  wire [`PAS_REG_ADDR_W-1:0] hdr_ra = hdr_full[`PAS_HDR_REG_MSB:`PAS_HDR_REG_LSB];
  // address zero matches like any other: isolation never blocks management
  wire addr_hit = (hdr_phy == strap_reg);
  wire op_ok = (hdr_op == `PAS_OP_READ) || (hdr_op == `PAS_OP_WRITE);
  wire [`PAS_DATA_W-1:0] sh_in = {sh_reg[`PAS_DATA_W-2:0], bit_in};

  assign wr_commit = mdc_rise && (mf_reg == pas_pkg::PAS_MF_DATA) && !is_read_reg && (cnt_reg == `PAS_DATA_LAST);
  assign wr_addr = ra_reg;
  assign wr_data = sh_in;

  always_comb begin
    mf_next = mf_reg;
    pre_seen_next = pre_seen_reg;
    ones_next = ones_reg;
    cnt_next = cnt_reg;
    hdr_next = hdr_reg;
    is_read_next = is_read_reg;
    ra_next = ra_reg;
    sh_next = sh_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    if (mdc_rise) begin
      ones_next = bit_in ? ((ones_reg == `PAS_PREAMBLE_ONES) ? ones_reg : ones_reg + `PAS_ONES_ONE) : '0;
      if (ones_next == `PAS_PREAMBLE_ONES) begin
        pre_seen_next = 1'b1;
      end
      unique case (mf_reg)
        pas_pkg::PAS_MF_IDLE: begin
          if (!bit_in && pre_seen_reg) begin
            mf_next = pas_pkg::PAS_MF_START;
          end
        end
        pas_pkg::PAS_MF_START: begin
          mf_next = bit_in ? pas_pkg::PAS_MF_HDR : pas_pkg::PAS_MF_IDLE;
          cnt_next = '0;
        end
        pas_pkg::PAS_MF_HDR: begin
          hdr_next = hdr_full;
          cnt_next = cnt_reg + `PAS_CNT_ONE;
          if (cnt_reg == `PAS_HDR_LAST) begin
            cnt_next = '0;
            ra_next = hdr_ra;
            is_read_next = (hdr_op == `PAS_OP_READ);
            sh_next = reg_read(hdr_ra);
            mf_next = (addr_hit && op_ok) ? pas_pkg::PAS_MF_TA : pas_pkg::PAS_MF_IDLE;
          end
        end
        pas_pkg::PAS_MF_TA: begin
          cnt_next = cnt_reg + `PAS_CNT_ONE;
          if (cnt_reg == '0 && is_read_reg) begin
            oe_next = 1'b1;
            out_next = 1'b0;
          end
          if (cnt_reg == `PAS_TA_LAST) begin
            cnt_next = '0;
            mf_next = pas_pkg::PAS_MF_DATA;
            if (is_read_reg) begin
              out_next = sh_reg[`PAS_DATA_W-1];
              sh_next = {sh_reg[`PAS_DATA_W-2:0], 1'b0};
            end
          end
        end
        pas_pkg::PAS_MF_DATA: begin
          cnt_next = cnt_reg + `PAS_CNT_ONE;
          if (is_read_reg) begin
            out_next = sh_reg[`PAS_DATA_W-1];
            sh_next = {sh_reg[`PAS_DATA_W-2:0], 1'b0};
          end else begin
            sh_next = sh_in;
          end
          if (cnt_reg == `PAS_DATA_LAST) begin
            oe_next = 1'b0;
            out_next = 1'b0;
            cnt_next = '0;
            mf_next = pas_pkg::PAS_MF_IDLE;
          end
        end
        default: begin
          mf_next = pas_pkg::PAS_MF_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
    if (holding) begin
      // a hardware reset drops any frame in flight and asks for a fresh preamble
      mf_next = pas_pkg::PAS_MF_IDLE;
      pre_seen_next = 1'b0;
      ones_next = '0;
      oe_next = 1'b0;
      out_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mf_reg <= pas_pkg::PAS_MF_IDLE;
      mdc_prev_reg <= 1'b0;
      pre_seen_reg <= 1'b0;
      ones_reg <= '0;
      cnt_reg <= '0;
      hdr_reg <= '0;
      is_read_reg <= 1'b0;
      ra_reg <= '0;
      sh_reg <= '0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      mf_reg <= mf_next;
      mdc_prev_reg <= pins.mdc;
      pre_seen_reg <= pre_seen_next;
      ones_reg <= ones_next;
      cnt_reg <= cnt_next;
      hdr_reg <= hdr_next;
      is_read_reg <= is_read_next;
      ra_reg <= ra_next;
      sh_reg <= sh_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign MDIO_OUT = out_reg;
  assign MDIO_OE = oe_reg;
  assign PHY_ADDRESS = strap_reg;
  assign ISOLATE = basic_control_register_reg[`PAS_BASIC_CONTROL_REGISTER_ISOLATE_BIT];
  assign INIT_DONE = !holding;

endmodule

// [phy_address_strap_reset_tb.sv]
/* self-checking bench for the strap loader
   assumes filter and settle delays as handed over */
`timescale 1ns/1ns
`include "pas_defs.svh"
module phy_address_strap_reset_tb;
  localparam logic [4:0] CT = `PAS_REG_PHY_CONTROL;
  localparam logic [4:0] BC = `PAS_REG_BASIC_CONTROL;
  logic clk;
  logic rstn;
  logic reset;
  logic m_out;
  logic m_oe;
  logic mdc;
  logic mdio;
  logic [4:0] strap;
  logic [4:0] pa;
  logic iso;
  logic done;
  logic [15:0] rd;
  int miscompares;
  int tests_run;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  phy_address_strap_reset i_dut (.CORE_CLK(clk), .RSTN(rstn), .RESET(reset), .STRAP_ADDRESS_PINS(strap),
    .MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(m_out), .MDIO_OE(m_oe), .PHY_ADDRESS(pa), .ISOLATE(iso),
    .INIT_DONE(done));
  pas_sme_model i_sme (.clk(clk), .mdio_out(m_out), .mdio_oe(m_oe), .mdc(mdc), .mdio(mdio), .strap(strap));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rr(input logic [4:0] a, input logic [4:0] r);
    i_sme.xfer(`PAS_OP_READ, a, r, 16'h0000, rd);
  endtask
  task automatic wr(input logic [4:0] a, input logic [4:0] r, input logic [15:0] d);
    i_sme.xfer(`PAS_OP_WRITE, a, r, d, rd);
  endtask
  // straps change only while the reset pin is held, so the filter sees them settled
  task automatic hw_reset(input logic [4:0] s);
    reset = 1'b1;
    i_sme.set_strap(s);
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic t_straps();
    logic [4:0] tbl [4];
    tbl = '{5'h00, 5'h15, 5'h1f, 5'h0a};
    foreach (tbl[i]) begin
      hw_reset(tbl[i]);
      chk("phy_address", {11'h000, tbl[i]}, {11'h000, pa});
      chk("isolate", {15'h0000, tbl[i] == 5'h00}, {15'h0000, iso});
      rr(tbl[i], CT);
      chk("phy_control", {11'h000, tbl[i]}, rd);
      rr(tbl[i], BC);
      chk("basic_control", {5'h00, tbl[i] == 5'h00, 10'h000}, rd);
    end
    $display("test straps done");
  endtask
  task automatic t_regs();
    hw_reset(5'h0a);
    wr(5'h0a, CT, 16'hffff);
    rr(5'h0a, CT);
    chk("ctrl_rw", 16'hffea, rd);
    wr(5'h0a, BC, 16'h1234);
    wr(5'h0a, 5'h05, 16'hffff);
    rr(5'h0a, 5'h05);
    chk("unmapped", 16'h0000, rd);
    rr(5'h0b, BC);
    chk("other_addr", 16'hffff, rd);
    rr(5'h0a, BC);
    chk("basic_control_register_rw", 16'h1234, rd);
    hw_reset(5'h11);
    rr(5'h11, CT);
    chk("ctrl_reload", 16'h0011, rd);
    rr(5'h11, BC);
    chk("basic_control_register_reload", 16'h0000, rd);
    rr(5'h0a, CT);
    chk("old_addr", 16'hffff, rd);
    $display("test registers done");
  endtask
  // reset pin pulsed in the data phase of a read: the drive must stop and a fresh frame must work
  task automatic t_cut();
    logic [15:0] junk;
    hw_reset(5'h0a);
    fork
      i_sme.xfer(`PAS_OP_READ, 5'h0a, CT, 16'h0000, junk);
      begin
        repeat (1100) @(posedge clk);
        #1;
        reset = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
      end
    join
    chk("cut_done", 16'h0001, {15'h0000, done});
    chk("cut_oe", 16'h0000, {15'h0000, m_oe});
    rr(5'h0a, CT);
    chk("cut_recover", 16'h000a, rd);
    $display("test cut frame done");
  endtask
  initial begin
    miscompares = 0;
    tests_run = 0;
    rstn = 1'b0;
    reset = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_straps();
    t_regs();
    t_cut();
    print_verdict();
  end
endmodule
bind phy_address_strap_reset pas_strap_chk i_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .RESET(RESET),
  .STRAP_ADDRESS_PINS(STRAP_ADDRESS_PINS), .MDC(MDC), .MDIO_IN(MDIO_IN), .MDIO_OUT(MDIO_OUT),
  .MDIO_OE(MDIO_OE), .PHY_ADDRESS(PHY_ADDRESS), .ISOLATE(ISOLATE), .INIT_DONE(INIT_DONE));
